// *** hw/wvf_map.svh ***
// constants and functional notes for the weight vibration filter
// Functional notes
// - average successive readings, depth from averaging_depth
// - override makes output jump to new reading
// - count consecutive outliers, trigger at run limit
// - band width in display divisions, compare deviation
// - band of zero disables override entirely
`ifndef WVF_MAP_SVH
`define WVF_MAP_SVH
`define WVF_BAND_DISABLED 8'h00
`define WVF_DEPTH_MAX 4'h7
`define WVF_RUN_RESET 8'h00
`define WVF_ACC_RESET 32'h0000_0000
`endif

// *** hw/wvf_pkg.sv ***
// types for the weight vibration filter
package wvf_pkg;
  typedef struct packed {
    logic [23:0] weight;
    logic jumped;
  } wvf_out_t;
endpackage : wvf_pkg

// *** hw/wvf_skid.sv ***
// two-entry buffer on the filtered output path
module wvf_skid
  import wvf_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // upstream
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire wvf_out_t in_data_in,
  // downstream
  output logic out_valid_out,
  input wire logic out_ready_in,
  output wvf_out_t out_data_out
);
  wvf_out_t mem_reg [2];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] count_reg;
  logic push;
  logic pop;

  assign in_ready_out = (count_reg != 2'h2);
  assign out_valid_out = (count_reg != 2'h0);
  assign out_data_out = mem_reg[rd_ptr_reg];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (pop) rd_ptr_reg <= ~rd_ptr_reg;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : wvf_skid

// *** hw/wvf_filter.sv ***
// averaging filter with outlier-run override
`include "wvf_map.svh"
module wvf_filter
  import wvf_pkg::*;
#(
  parameter int WIDTH = 24
) (
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // configuration, held static while running
  input wire logic [3:0] averaging_depth_in,
  input wire logic [7:0] override_band_divisions_in,
  input wire logic [7:0] outlier_run_length_limit_in,
  input wire logic [15:0] division_size_in,
  // readings from the converter front end
  input wire logic rd_valid_in,
  output logic rd_ready_out,
  input wire logic signed [WIDTH-1:0] rd_weight_in,
  // filtered weight
  output logic flt_valid_out,
  input wire logic flt_ready_in,
  output logic [WIDTH-1:0] flt_weight_out,
  output logic flt_jumped_out
);
  // signed accumulator: avg holds acc >> depth; fractional bits kept
  logic signed [WIDTH+7:0] acc_reg;
  logic signed [WIDTH+7:0] acc_next;
  logic [7:0] run_reg;
  logic st_valid_reg;
  wvf_out_t st_data_reg;
  logic [3:0] depth;
  logic signed [WIDTH-1:0] avg;
  logic signed [WIDTH:0] dev;
  logic [WIDTH:0] dev_abs;
  logic [WIDTH+16:0] band_w;
  logic outlier;
  logic trigger;
  logic take;
  logic st_ready;
  wvf_out_t buf_data;
  logic buf_valid;

  // depths past the limit would shift the accumulator's headroom away,
  // so they are pulled back to the deepest legal setting
  function automatic logic [3:0] clamp_depth(input logic [3:0] d);
    logic [3:0] r;
    r = d;
    if (d > `WVF_DEPTH_MAX) begin
      r = `WVF_DEPTH_MAX;
    end
    return r;
  endfunction : clamp_depth

  // pipeline: staging register, two-entry buffer, output register;
  // a reading taken at one edge is shown two edges later when the
  // consumer is ready, and a stall backs up through all three stages
  // before the converter side sees ready fall
  assign depth = clamp_depth(averaging_depth_in);
  assign avg = WIDTH'(acc_reg >>> depth);
  assign dev = {rd_weight_in[WIDTH-1], rd_weight_in} - {avg[WIDTH-1], avg};
  assign dev_abs = dev[WIDTH] ? (WIDTH+1)'(-dev) : dev;
  // band converted from divisions to counts
  assign band_w = override_band_divisions_in * division_size_in;
  assign outlier = (override_band_divisions_in != `WVF_BAND_DISABLED) &&
                   ({16'h0000, dev_abs} > band_w);
  assign trigger = outlier &&
                   ((run_reg + 8'h01) >= outlier_run_length_limit_in);
  // stall readings while the staging stage cannot drain
  assign rd_ready_out = !st_valid_reg || st_ready;
  assign take = rd_valid_in && rd_ready_out;

  always_comb begin
    if (trigger) begin
      // reload so that the average equals the new reading
      acc_next = (WIDTH+8)'($signed(rd_weight_in)) <<< depth;
    end else begin
      // exponential running average of depth 2^n
      acc_next = acc_reg - (acc_reg >>> depth) +
                 (WIDTH+8)'($signed(rd_weight_in));
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      acc_reg <= `WVF_ACC_RESET;
    end else if (take) begin
      acc_reg <= acc_next;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      run_reg <= `WVF_RUN_RESET;
    end else if (take) begin
      if (!outlier || trigger) begin
        run_reg <= `WVF_RUN_RESET;
      end else if (run_reg != 8'hff) begin
        run_reg <= run_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_valid_reg <= 1'b0;
      st_data_reg <= '0;
    end else if (take) begin
      st_valid_reg <= 1'b1;
      st_data_reg.weight <= WIDTH'(acc_next >>> depth);
      st_data_reg.jumped <= trigger;
    end else if (st_ready) begin
      st_valid_reg <= 1'b0;
    end
  end

  wvf_skid u_skid (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .in_valid_in(st_valid_reg),
    .in_ready_out(st_ready),
    .in_data_in(st_data_reg),
    .out_valid_out(buf_valid),
    .out_ready_in(!flt_valid_out || flt_ready_in),
    .out_data_out(buf_data)
  );

  // output register so that every flt_ output leaves a flip-flop
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      flt_valid_out <= 1'b0;
      flt_weight_out <= '0;
      flt_jumped_out <= 1'b0;
    end else if (!flt_valid_out || flt_ready_in) begin
      flt_valid_out <= buf_valid;
      flt_weight_out <= buf_data.weight;
      flt_jumped_out <= buf_data.jumped;
    end
  end

  a_band_disabled: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (override_band_divisions_in == `WVF_BAND_DISABLED) |-> !trigger)
    else $error("override fired with band disabled");

  a_run_clears: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (take && !outlier) |=> (run_reg == 8'h00))
    else $error("run count not cleared by in-band reading");

  a_jump_value: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (take && trigger) |=> (avg == $past(rd_weight_in)))
    else $error("override did not jump to new reading");

  a_run_counts: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (take && outlier && !trigger && run_reg != 8'hff)
      |=> (run_reg == $past(run_reg) + 8'h01))
    else $error("outlier run not counted");

  a_avg_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !take |=> $stable(acc_reg))
    else $error("average changed without a reading");

  a_outlier_band: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (override_band_divisions_in != `WVF_BAND_DISABLED &&
     {16'h0000, dev_abs} <= band_w) |-> !outlier)
    else $error("in-band reading flagged as outlier");

  a_depth_range: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    depth <= `WVF_DEPTH_MAX)
    else $error("averaging depth beyond its limit");

  a_jump_flag: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (take && trigger) |=> (st_valid_reg && st_data_reg.jumped))
    else $error("jump not flagged on the staged word");

  a_no_jump_flag: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (take && !trigger) |=> !st_data_reg.jumped)
    else $error("jump flagged without an override");

  a_stage_avg: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    take |=> (st_data_reg.weight == avg))
    else $error("staged word differs from the new average");

  a_run_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !take |=> $stable(run_reg))
    else $error("outlier run changed without a reading");

  a_run_restart: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (take && trigger) |=> (run_reg == 8'h00))
    else $error("outlier run not restarted after a jump");

  a_run_saturate: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (take && outlier && !trigger && run_reg == 8'hff)
      |=> (run_reg == 8'hff))
    else $error("outlier run wrapped around");

  a_stage_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (st_valid_reg && !st_ready)
      |=> (st_valid_reg && $stable(st_data_reg)))
    else $error("staged word lost during a stall");

  a_out_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (flt_valid_out && !flt_ready_in)
      |=> (flt_valid_out && $stable(flt_weight_out) &&
           $stable(flt_jumped_out)))
    else $error("output word changed while the consumer stalled");
endmodule : wvf_filter

// *** verification/wvf_conv_model.sv ***
// converter front end model feeding readings
module wvf_conv_model (
  // clock
  input wire logic clk_sys_in,
  // reading handshake
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic signed [23:0] rd_weight_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rd_valid_out = 1'b0;
    rd_weight_out = 24'h000000;
  end
  // entered at a falling edge; word held until the edge that takes it
  task automatic send(input logic signed [23:0] x);
    rd_valid_out = 1'b1;
    rd_weight_out = x;
    while (rd_ready_in !== 1'b1) @(negedge clk_sys_in);
    @(negedge clk_sys_in);
  endtask : send
  // a released bus is scrambled so nobody leans on a stale word
  task automatic idle();
    rd_valid_out = 1'b0;
    rd_weight_out = ~rd_weight_out;
  endtask : idle
endmodule : wvf_conv_model

// *** verification/wvf_filter_test.sv ***
// self-checking bench for the weight vibration filter
module wvf_filter_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] band = 8'h00;
  logic [7:0] lim = 8'h01;
  logic [3:0] dep = 4'h1;
  logic rv, rr, fv, fj;
  logic fr = 1'b0;
  logic signed [23:0] rw;
  logic [23:0] fw;
  int fails = 0;
  int checks_done = 0;
  initial forever #2.5 clk = ~clk;
  wvf_conv_model wvf_conv_model_i (.clk_sys_in(clk), .rd_valid_out(rv),
    .rd_ready_in(rr), .rd_weight_out(rw));
  wvf_filter wvf_filter_i (.clk_sys_in(clk), .rst_in(rst),
    .averaging_depth_in(dep), .override_band_divisions_in(band),
    .outlier_run_length_limit_in(lim), .division_size_in(16'h000a),
    .rd_valid_in(rv), .rd_ready_out(rr), .rd_weight_in(rw),
    .flt_valid_out(fv), .flt_ready_in(fr), .flt_weight_out(fw),
    .flt_jumped_out(fj));
  task automatic check(input logic [23:0] s, input logic [23:0] e,
      input string what);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", what, e, s);
    end
  endtask : check
  // three readings in, consumer stalls, then three words out
  task automatic run(input logic [7:0] b, input logic [7:0] l,
      input logic [71:0] x, input logic [71:0] e, input logic [2:0] j);
    int n;
    int k;
    @(negedge clk);
    rst = 1'b1;
    band = b;
    lim = l;
    fr = 1'b0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    for (n = 0; n < 3; n++) wvf_conv_model_i.send(x[71-24*n -: 24]);
    wvf_conv_model_i.idle();
    repeat (3) @(negedge clk);
    fr = 1'b1;
    n = 0;
    k = 0;
    while (n < 3 && k < 20) begin
      if (fv === 1'b1) begin
        check(fw, e[71-24*n -: 24], "weight");
        check({23'h0, fj}, {23'h0, j[2-n]}, "jumped");
        n++;
      end
      k++;
      @(negedge clk);
    end
    check(24'(n), 24'h000003, "word count");
  endtask : run
  task automatic test_average();
    run(8'h00, 8'h01, {3{24'h000064}},
      {24'h32, 24'h4b, 24'h57}, 3'h0);
    $display("test average done");
  endtask : test_average
  task automatic test_override();
    run(8'h01, 8'h02, {3{24'h000064}},
      {24'h32, 24'h64, 24'h64}, 3'h2);
    $display("test override done");
  endtask : test_override
  task automatic test_run_clear();
    run(8'h01, 8'h02, {24'h64, 24'h32, 24'hc8},
      {24'h32, 24'h32, 24'h7d}, 3'h0);
    $display("test run clear done");
  endtask : test_run_clear
  // depth zero passes every reading straight through
  task automatic test_depth_zero();
    dep = 4'h0;
    run(8'h00, 8'h01, {24'h64, 24'h32, 24'hc8},
      {24'h64, 24'h32, 24'hc8}, 3'h0);
    $display("test depth zero done");
  endtask : test_depth_zero
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run
  initial begin
    #5000;
    fails++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk);
    test_average();
    test_override();
    test_run_clear();
    test_depth_zero();
    complete_run();
  end
endmodule : wvf_filter_test
